/* asr_pkg.sv */
package asr_pkg;
    localparam int CELL_BYTES     = 53;
    localparam int HDR_BYTES      = 5;
    localparam int PAY_BYTES      = 48;
    localparam int MAX_VC         = 65536;
    localparam int MAX_ACTIVE_VC  = 8191;
    localparam int RATE_SLOTS     = 8;
    localparam int RATE_W         = 3;
    localparam int CBR_VCI        = 16'h0020;
    localparam int OAM_VCI_SEG    = 16'h0003;
    localparam int OAM_VCI_E2E    = 16'h0004;
    localparam int BECN_VCI       = 16'h0006;
    localparam int RESTORE_US     = 1000;
    localparam int CLK_MHZ        = 25;
    localparam int RESTORE_CYC    = RESTORE_US * CLK_MHZ;
    localparam int PTI_EOF_BIT    = 1;
    localparam logic [1:0] ST_COM = 2'h0;
    localparam logic [1:0] ST_EOM = 2'h1;
    localparam logic [1:0] ST_BOM = 2'h2;
    localparam logic [1:0] ST_SSM = 2'h3;

    typedef struct packed {
        logic [11:0] vpi;
        logic [15:0] vci;
        logic [2:0]  pti;
        logic        clp;
    } asr_hdr_s;

    typedef struct packed {
        logic [7:0] data;
        logic       sof;
        logic       eof;
    } asr_byte_s;

    typedef struct packed {
        logic [15:0] vc;
        logic        aal34;
        logic [9:0]  mid;
        logic        last;
        logic [1:0]  st;
    } asr_cell_s;
endpackage

/* asr_fifo.sv */
`timescale 1ns/100ps
module asr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    rd_reg;
    logic [AW:0]      cnt_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_reg];

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

/* asr_core.sv */
`timescale 1ns/100ps
// Function
// - Cells on the line are 53 bytes: 5 header then 48 payload.
// - Circuit numbers span 65,536; 8,191 active per direction.
// - One byte per clock each way sustains line rate.
// - Packet plus descriptor cut into cells, headers added, sent out.
// - Maintenance cells dropped, except PTI-marked ones on the constant-rate or congestion circuit.
// - Reassembly id is VCI plus MID bits 9:8, or VPI low byte plus VCI.
// - Headers stripped; completed frame queued to software.
// - Constant-rate cells get headers and preempt packet cells.
// - Received constant-rate cells go to their own queue.
// - Cells interleaved; eight programmable peak gaps.
// - One leaky bucket shared by all circuits bounds average rate.
// - Buffer handed back when last cell sent.
// - First cell opens a buffer; later cells appended.
// - Last cell stored, then completion reported.
// - Adaptation fields checked; errors reported.
// - Software sees only packet-level events.
// - Tables and packet data stay in outside memories.
// - Congestion cells forwarded to transmit side.
// - Each congestion notice slows packet cells one slot further, up to slot 7.
// - Quiet interval restores rate one step at a time.
// - AAL5 last cell has user indication 1, others 0.
// - AAL3/4 segments carry BOM, COM, EOM or SSM type.
module asr_core
    import asr_pkg::*;
#(
    parameter int RESTORE_CYCLES = RESTORE_CYC,
    parameter int FIFO_DEPTH     = 4
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       tx_pkt_valid,
    output logic            tx_pkt_ready,
    input  wire asr_cell_s  tx_pkt_cell,
    input  wire logic [2:0] tx_rate_sel,
    input  wire logic [7:0] tx_bucket_lim,
    input  wire logic [7:0] tx_byte,
    input  wire logic       cbr_valid,
    output logic            cbr_ready,
    input  wire asr_hdr_s   cbr_hdr,
    output logic            tx_byte_rd,
    output logic            tx_done,
    output logic [15:0]     tx_done_vc,
    output logic            line_tx_valid,
    input  wire logic       line_tx_ready,
    output asr_byte_s       line_tx,
    input  wire logic       line_rx_valid,
    input  wire asr_byte_s  line_rx,
    input  wire logic [15:0] gap_cfg [RATE_SLOTS],
    input  wire logic       rid_vci_mid,
    output asr_byte_s       rx_out,
    output logic            rx_out_valid,
    output logic            rx_cbr_valid,
    output logic [25:0]     rx_rid,
    output logic            rx_open,
    output logic            rx_done,
    output logic            rx_err,
    output logic            becn_valid,
    output logic [15:0]     becn_vc
);
    // Reset release through two stages
    logic rst_s1, rst_s2;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end
    wire srst_n = rst_s2;

    // ---------------- Transmit ----------------
    typedef enum logic [1:0] {TX_IDLE, TX_HDR, TX_PAY} asr_tx_e;
    asr_tx_e   tx_st_reg;
    asr_cell_s cur_reg;
    logic      is_cbr_reg;
    asr_hdr_s  cbr_h_reg;
    logic [5:0] idx_reg;
    logic [15:0] gap_reg;
    logic [7:0] bucket_reg;
    logic [2:0] throttle_reg;
    logic [31:0] quiet_reg;
    logic      fifo_in_ready;
    asr_byte_s tx_b;
    logic      tx_b_valid;
    logic [39:0] hdr_bits;
    logic      pace_ok;
    logic      becn_int;
    logic [2:0] eff_rate;

    // Header field packing per cell type
    always_comb begin
        hdr_bits = '0;
        if (is_cbr_reg) begin
            hdr_bits = {4'h0, cbr_h_reg.vpi[7:0], cbr_h_reg.vci,
                        cbr_h_reg.pti, cbr_h_reg.clp, 8'h00};
        end else begin
            hdr_bits = {12'h000, cur_reg.vc, 3'(cur_reg.last && !cur_reg.aal34)
                        << PTI_EOF_BIT >> 1, 1'b0, 8'h00};
        end
    end

    // Slower rate after congestion, capped at slot 7
    assign eff_rate = (3'(tx_rate_sel) + throttle_reg < tx_rate_sel) ?
                      3'h7 : tx_rate_sel + throttle_reg;
    // Peak gap and average bucket both gate a new packet cell
    assign pace_ok  = (gap_reg == '0) && (bucket_reg < tx_bucket_lim);

    assign cbr_ready    = (tx_st_reg == TX_IDLE) && srst_n;
    assign tx_pkt_ready = (tx_st_reg == TX_IDLE) && !cbr_valid && pace_ok
                          && srst_n;
    assign tx_b_valid   = (tx_st_reg != TX_IDLE);
    // Segment type byte takes no packet byte, so none is lost
    assign tx_byte_rd   = (tx_st_reg == TX_PAY) && fifo_in_ready && !is_cbr_reg
                          && !(cur_reg.aal34 && idx_reg == '0);

    always_comb begin
        tx_b = '0;
        tx_b.sof = (tx_st_reg == TX_HDR) && (idx_reg == '0);
        tx_b.eof = (tx_st_reg == TX_PAY) && (idx_reg == 6'(PAY_BYTES-1));
        if (tx_st_reg == TX_HDR) begin
            tx_b.data = hdr_bits[39 - 8*idx_reg[2:0] -: 8];
        end else if (!is_cbr_reg && cur_reg.aal34 && idx_reg == '0) begin
            tx_b.data = {cur_reg.st, 6'h00};
        end else begin
            tx_b.data = tx_byte;
        end
    end

    always_ff @(posedge core_clk or negedge srst_n) begin
        if (!srst_n) begin
            tx_st_reg  <= TX_IDLE;
            idx_reg    <= '0;
            is_cbr_reg <= 1'b0;
            cur_reg    <= '0;
            cbr_h_reg  <= '0;
        end else begin
            case (tx_st_reg)
                TX_IDLE: begin
                    idx_reg <= '0;
                    if (cbr_valid) begin
                        is_cbr_reg <= 1'b1;
                        cbr_h_reg  <= cbr_hdr;
                        tx_st_reg  <= TX_HDR;
                    end else if (tx_pkt_valid && pace_ok) begin
                        is_cbr_reg <= 1'b0;
                        cur_reg    <= tx_pkt_cell;
                        tx_st_reg  <= TX_HDR;
                    end
                end
                TX_HDR: if (fifo_in_ready) begin
                    if (idx_reg == 6'(HDR_BYTES-1)) begin
                        idx_reg   <= '0;
                        tx_st_reg <= TX_PAY;
                    end else begin
                        idx_reg <= idx_reg + 1'b1;
                    end
                end
                TX_PAY: if (fifo_in_ready) begin
                    if (idx_reg == 6'(PAY_BYTES-1)) begin
                        tx_st_reg <= TX_IDLE;
                    end else begin
                        idx_reg <= idx_reg + 1'b1;
                    end
                end
                default: tx_st_reg <= TX_IDLE;
            endcase
        end
    end

    wire cell_end = (tx_st_reg == TX_PAY) && fifo_in_ready
                    && (idx_reg == 6'(PAY_BYTES-1)) && !is_cbr_reg;

    // Peak gap and leaky bucket
    always_ff @(posedge core_clk or negedge srst_n) begin
        if (!srst_n) begin
            gap_reg    <= '0;
            bucket_reg <= '0;
        end else if (cell_end) begin
            gap_reg    <= gap_cfg[eff_rate];
            bucket_reg <= bucket_reg + 8'h01;
        end else begin
            if (gap_reg != '0) begin
                gap_reg <= gap_reg - 1'b1;
            end
            if (bucket_reg != '0 && gap_reg == '0) begin
                bucket_reg <= bucket_reg - 1'b1;
            end
        end
    end

    // Buffer return on last cell
    always_ff @(posedge core_clk or negedge srst_n) begin
        if (!srst_n) begin
            tx_done    <= 1'b0;
            tx_done_vc <= '0;
        end else begin
            tx_done    <= cell_end && cur_reg.last;
            tx_done_vc <= cur_reg.vc;
        end
    end

    // Congestion throttle and gradual restore
    always_ff @(posedge core_clk or negedge srst_n) begin
        if (!srst_n) begin
            throttle_reg <= '0;
            quiet_reg    <= '0;
        end else if (becn_int) begin
            if (throttle_reg != 3'h7) begin
                throttle_reg <= throttle_reg + 1'b1;
            end
            quiet_reg <= '0;
        end else if (throttle_reg != '0) begin
            if (quiet_reg >= 32'(RESTORE_CYCLES - 1)) begin
                throttle_reg <= throttle_reg - 1'b1;
                quiet_reg    <= '0;
            end else begin
                quiet_reg <= quiet_reg + 1'b1;
            end
        end
    end

    // Byte FIFO toward the line
    asr_fifo #(.WIDTH($bits(asr_byte_s)), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .core_clk  (core_clk),
        .rst_n     (srst_n),
        .in_valid  (tx_b_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (tx_b),
        .out_valid (line_tx_valid),
        .out_ready (line_tx_ready),
        .out_data  (line_tx)
    );

    // ---------------- Receive ----------------
    logic [5:0]  rx_idx_reg;
    logic        rx_in_hdr_reg;
    logic [39:0] rx_hdr_reg;
    logic [1:0]  rx_kind_reg; // 0 data, 1 drop, 2 cbr, 3 becn
    logic        rx_busy_reg;
    wire [15:0]  rvci = rx_hdr_reg[27:12];
    wire [2:0]   rpti = rx_hdr_reg[11:9];

    always_ff @(posedge core_clk or negedge srst_n) begin
        if (!srst_n) begin
            rx_idx_reg    <= '0;
            rx_in_hdr_reg <= 1'b1;
            rx_hdr_reg    <= '0;
        end else if (line_rx_valid) begin
            if (line_rx.sof) begin
                rx_in_hdr_reg <= 1'b1;
                rx_idx_reg    <= 6'h01;
                rx_hdr_reg    <= {line_rx.data, 32'h0};
            end else if (rx_in_hdr_reg) begin
                rx_hdr_reg <= rx_hdr_reg | (40'(line_rx.data)
                              << (8*(4 - 32'(rx_idx_reg))));
                if (rx_idx_reg == 6'(HDR_BYTES-1)) begin
                    rx_in_hdr_reg <= 1'b0;
                    rx_idx_reg    <= '0;
                end else begin
                    rx_idx_reg <= rx_idx_reg + 1'b1;
                end
            end else begin
                rx_idx_reg <= rx_idx_reg + 1'b1;
            end
        end
    end

    logic [1:0] rx_kind_reg_n;
    // Classify once header complete
    always_comb begin
        rx_kind_reg_n = 2'd0;
        if (rpti[2] || rvci == 16'(OAM_VCI_SEG) || rvci == 16'(OAM_VCI_E2E))
            rx_kind_reg_n = 2'd1;
        if (rvci == 16'(BECN_VCI))
            rx_kind_reg_n = 2'd3;
        else if (rvci == 16'(CBR_VCI))
            rx_kind_reg_n = 2'd2;
    end

    wire pay_byte = line_rx_valid && !rx_in_hdr_reg && !line_rx.sof;
    wire first_pay = pay_byte && rx_idx_reg == '0;
    wire last_pay  = pay_byte && rx_idx_reg == 6'(PAY_BYTES-1);
    wire [1:0] kind = first_pay ? rx_kind_reg_n : rx_kind_reg;
    logic [1:0] rx_st_reg;

    always_ff @(posedge core_clk or negedge srst_n) begin
        if (!srst_n) begin
            rx_out       <= '0;
            rx_kind_reg  <= '0;
            rx_out_valid <= 1'b0;
            rx_cbr_valid <= 1'b0;
            rx_rid       <= '0;
            rx_open      <= 1'b0;
            rx_done      <= 1'b0;
            rx_err       <= 1'b0;
            becn_valid   <= 1'b0;
            becn_vc      <= '0;
            rx_busy_reg  <= 1'b0;
            rx_st_reg    <= '0;
        end else begin
            if (first_pay) begin
                rx_kind_reg <= rx_kind_reg_n;
                rx_st_reg   <= line_rx.data[7:6];
                rx_rid <= rid_vci_mid ?
                    {rvci, line_rx.data[1:0], 8'h00} :
                    {rx_hdr_reg[35:28], rvci, 2'b00};
            end
            rx_out_valid <= pay_byte && kind == 2'd0;
            rx_cbr_valid <= pay_byte && kind == 2'd2;
            rx_out.data  <= line_rx.data;
            rx_out.sof   <= first_pay;
            rx_out.eof   <= last_pay;
            becn_valid   <= last_pay && kind == 2'd3;
            becn_vc      <= rvci;
            rx_open      <= first_pay && kind == 2'd0 && !rx_busy_reg;
            rx_done      <= 1'b0;
            rx_err       <= 1'b0;
            if (first_pay && kind == 2'd0 && !rx_busy_reg)
                rx_busy_reg <= 1'b1;
            if (last_pay && kind == 2'd0 &&
                (rpti[0] || rx_st_reg[0] == 1'b1 && rx_st_reg != ST_BOM)) begin
                rx_done     <= 1'b1;
                rx_busy_reg <= 1'b0;
            end
            if (first_pay && kind == 2'd0 && rx_busy_reg &&
                line_rx.data[7] == 1'b1)
                rx_err <= 1'b1;
        end
    end
    assign becn_int = becn_valid;

    property p_cell_len;
        @(posedge core_clk) disable iff (!srst_n)
        (tx_st_reg == TX_IDLE && $past(tx_st_reg) == TX_PAY)
            |-> $past(idx_reg) == 6'(PAY_BYTES-1);
    endproperty
    a_cell_len: assert property (p_cell_len) else $error("bad cell len");

    property p_cbr_first;
        @(posedge core_clk) disable iff (!srst_n)
        (tx_st_reg == TX_IDLE && cbr_valid) |=> is_cbr_reg;
    endproperty
    a_cbr_first: assert property (p_cbr_first) else $error("cbr lost");

    property p_done;
        @(posedge core_clk) disable iff (!srst_n)
        (cell_end && cur_reg.last) |=> tx_done;
    endproperty
    a_done: assert property (p_done) else $error("no return");

    property p_oam;
        @(posedge core_clk) disable iff (!srst_n)
        (pay_byte && kind == 2'd1) |=> !rx_out_valid;
    endproperty
    a_oam: assert property (p_oam) else $error("oam passed");

    property p_gap;
        @(posedge core_clk) disable iff (!srst_n)
        (gap_reg != '0) |-> !tx_pkt_ready;
    endproperty
    a_gap: assert property (p_gap) else $error("gap broken");

    property p_bucket;
        @(posedge core_clk) disable iff (!srst_n)
        (bucket_reg >= tx_bucket_lim) |-> !tx_pkt_ready;
    endproperty
    a_bucket: assert property (p_bucket) else $error("bucket");

    property p_throttle;
        @(posedge core_clk) disable iff (!srst_n)
        (becn_int && throttle_reg != 3'h7)
            |=> throttle_reg == $past(throttle_reg) + 3'h1;
    endproperty
    a_throttle: assert property (p_throttle) else $error("no throttle");

    property p_restore;
        @(posedge core_clk) disable iff (!srst_n)
        (throttle_reg != '0 && !becn_int)
            |=> throttle_reg >= $past(throttle_reg) - 3'h1;
    endproperty
    a_restore: assert property (p_restore) else $error("restore jump");
endmodule

/* asr_line_model.sv */
`timescale 1ns/100ps
module asr_line_model
    import asr_pkg::*;
(
    input  wire logic      core_clk,
    input  wire logic      rst_n,
    input  wire logic      stall,
    input  wire logic      line_tx_valid,
    output logic           line_tx_ready,
    input  wire asr_byte_s line_tx,
    output logic           line_rx_valid,
    output asr_byte_s      line_rx
);
    asr_byte_s cap [$];
    logic      phase;

    initial begin
        line_rx_valid = 1'h0;
        line_rx       = '0;
    end

    // Slow mode drains every other cycle so the FIFO backs up
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase         <= 1'h0;
            line_tx_ready <= 1'h0;
        end else begin
            phase         <= ~phase;
            line_tx_ready <= !stall || phase;
        end
    end

    always @(posedge core_clk) begin
        if (rst_n && line_tx_valid && line_tx_ready) begin
            cap.push_back(line_tx);
        end
    end

    // Whole cell, header first, no idle byte inside
    task automatic send_cell(input logic [11:0] vpi, input logic [15:0] vci,
                             input logic [2:0] pti, input logic [7:0] fill);
        logic [7:0] b;
        b = 8'h00;
        for (int i = 0; i < CELL_BYTES; i++) begin
            case (i)
                0: b = vpi[11:4];
                1: b = {vpi[3:0], vci[15:12]};
                2: b = vci[11:4];
                3: b = {vci[3:0], pti, 1'h0};
                4: b = 8'h00;
                default: b = fill + 8'(i);
            endcase
            @(posedge core_clk);
            line_rx_valid <= 1'h1;
            line_rx.data  <= b;
            line_rx.sof   <= (i == 0);
            line_rx.eof   <= (i == CELL_BYTES - 1);
        end
        @(posedge core_clk);
        line_rx_valid <= 1'h0;
        line_rx.sof   <= 1'h0;
        line_rx.eof   <= 1'h0;
        // Released bus must not look like a held byte
        line_rx.data  <= ~b;
    endtask
endmodule

/* tb_atm_segment_reassemble.sv */
`timescale 1ns/100ps
module tb_atm_segment_reassemble
    import asr_pkg::*;
;
    logic        core_clk;
    logic        rst_n;
    logic        stall;
    logic        tx_pkt_valid;
    logic        tx_pkt_ready;
    asr_cell_s   tx_pkt_cell;
    logic [2:0]  tx_rate_sel;
    logic [7:0]  tx_bucket_lim;
    logic [7:0]  tx_byte = 8'h00;
    logic        cbr_valid;
    logic        cbr_ready;
    asr_hdr_s    cbr_hdr;
    logic        tx_byte_rd;
    logic        tx_done;
    logic [15:0] tx_done_vc;
    logic        line_tx_valid;
    logic        line_tx_ready;
    asr_byte_s   line_tx;
    logic        line_rx_valid;
    asr_byte_s   line_rx;
    logic [15:0] gap_cfg [RATE_SLOTS];
    logic        rid_vci_mid;
    logic        rx_out_valid;
    logic        rx_cbr_valid;
    logic        rx_open;
    logic        rx_done;
    logic        becn_valid;
    logic [25:0] rx_rid;
    logic [15:0] becn_vc;
    int          fails;
    int          total_checks;
    int          n_out;
    int          n_cbr;
    int          n_open;
    int          n_done;
    int          n_txd;
    int          n_becn;
    time         t_take [$];

    asr_core #(.RESTORE_CYCLES(50), .FIFO_DEPTH(4)) dut_u (
        .core_clk(core_clk), .rst_n(rst_n), .tx_pkt_valid(tx_pkt_valid),
        .tx_pkt_ready(tx_pkt_ready), .tx_pkt_cell(tx_pkt_cell),
        .tx_rate_sel(tx_rate_sel), .tx_bucket_lim(tx_bucket_lim),
        .tx_byte(tx_byte), .cbr_valid(cbr_valid), .cbr_ready(cbr_ready),
        .cbr_hdr(cbr_hdr), .tx_byte_rd(tx_byte_rd), .tx_done(tx_done),
        .tx_done_vc(tx_done_vc), .line_tx_valid(line_tx_valid),
        .line_tx_ready(line_tx_ready), .line_tx(line_tx),
        .line_rx_valid(line_rx_valid), .line_rx(line_rx),
        .gap_cfg(gap_cfg), .rid_vci_mid(rid_vci_mid), .rx_out(),
        .rx_out_valid(rx_out_valid), .rx_cbr_valid(rx_cbr_valid),
        .rx_rid(rx_rid), .rx_open(rx_open), .rx_done(rx_done), .rx_err(),
        .becn_valid(becn_valid), .becn_vc(becn_vc)
    );

    asr_line_model line_u (
        .core_clk(core_clk), .rst_n(rst_n), .stall(stall),
        .line_tx_valid(line_tx_valid), .line_tx_ready(line_tx_ready),
        .line_tx(line_tx), .line_rx_valid(line_rx_valid), .line_rx(line_rx)
    );

    always #20 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        n_out  <= n_out + int'(rx_out_valid === 1'h1);
        n_cbr  <= n_cbr + int'(rx_cbr_valid === 1'h1);
        n_open <= n_open + int'(rx_open === 1'h1);
        n_done <= n_done + int'(rx_done === 1'h1);
        n_txd  <= n_txd + int'(tx_done === 1'h1);
        n_becn <= n_becn + int'(becn_valid === 1'h1);
        if (tx_byte_rd === 1'h1) begin
            tx_byte <= tx_byte + 8'h01;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        if (fails == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic wait_cap(input int n);
        for (int k = 0; k < 4000 && line_u.cap.size() < n; k++) begin
            @(negedge core_clk);
        end
        repeat (8) @(negedge core_clk);
    endtask

    // Request held until the rising edge after ready is seen high at a falling edge
    task automatic request(input logic cbr, input asr_cell_s c);
        @(posedge core_clk);
        if (cbr) begin
            cbr_valid <= 1'h1;
        end else begin
            tx_pkt_cell  <= c;
            tx_pkt_valid <= 1'h1;
        end
        for (int k = 0; k < 4000; k++) begin
            @(negedge core_clk);
            if ((cbr ? cbr_ready : tx_pkt_ready) === 1'h1) break;
        end
        @(posedge core_clk);
        t_take.push_back($time);
        if (cbr) begin
            cbr_valid <= 1'h0;
        end else begin
            tx_pkt_valid <= 1'h0;
        end
    endtask

    task automatic t_tx_aal5();
        asr_cell_s c;
        int        b_txd;
        line_u.cap.delete();
        t_take.delete();
        b_txd = n_txd;
        @(posedge core_clk);
        stall       <= 1'h1;
        tx_rate_sel <= 3'h3;
        c = '{vc: 16'h0050, aal34: 1'h0, mid: 10'h000, last: 1'h0, st: ST_COM};
        request(1'h0, c);
        c.last = 1'h1;
        request(1'h0, c);
        wait_cap(106);
        check(line_u.cap.size(), 106);
        check(32'(t_take[1] - t_take[0] >= 256 * 40), 1);
        for (int i = 0; i < 106; i++) begin
            check({line_u.cap[i].sof, line_u.cap[i].eof},
                  {i % 53 == 0, i % 53 == 52});
            if (i % 53 >= HDR_BYTES)
                check(line_u.cap[i].data, (i / 53) * 48 + i % 53 - 5);
        end
        check(line_u.cap[2].data, 8'h05);
        check(line_u.cap[3].data[1], 1'h0);
        check(line_u.cap[56].data[1], 1'h1);
        check(n_txd - b_txd, 1);
        check(tx_done_vc, 16'h0050);
    endtask

    task automatic t_tx_aal34();
        logic [1:0] st_tab [4];
        asr_cell_s  c;
        int         b_txd;
        st_tab = '{ST_BOM, ST_COM, ST_EOM, ST_SSM};
        line_u.cap.delete();
        b_txd = n_txd;
        @(posedge core_clk);
        stall       <= 1'h0;
        tx_rate_sel <= 3'h0;
        for (int k = 0; k < 4; k++) begin
            c = '{vc: 16'h0070, aal34: 1'h1, mid: 10'h015,
                  last: (k >= 2), st: st_tab[k]};
            request(1'h0, c);
        end
        wait_cap(212);
        for (int k = 0; k < 4; k++) begin
            check(line_u.cap[k * 53 + 5].data[7:6], st_tab[k]);
            check(line_u.cap[k * 53 + 2].data, 8'h07);
        end
        check(n_txd - b_txd, 2);
    endtask

    // Both requests at one edge; constant-rate cell must leave first
    task automatic t_cbr();
        asr_cell_s c;
        line_u.cap.delete();
        c = '{vc: 16'h0050, aal34: 1'h0, mid: 10'h000, last: 1'h1, st: ST_COM};
        fork
            request(1'h1, c);
            request(1'h0, c);
        join
        wait_cap(106);
        check(line_u.cap[2].data, 8'h02);
        check(line_u.cap[55].data, 8'h05);
        check({line_u.cap[52].eof, line_u.cap[105].eof}, 2'h3);
    endtask

    task automatic rx_case(input logic [15:0] vci, input logic [2:0] pti,
                           input int e_out, e_cbr, e_open, e_done, e_becn);
        int b_out, b_cbr, b_open, b_done, b_becn;
        b_out  = n_out;
        b_cbr  = n_cbr;
        b_open = n_open;
        b_done = n_done;
        b_becn = n_becn;
        line_u.send_cell(12'h001, vci, pti, 8'h30);
        repeat (20) @(negedge core_clk);
        check(n_out - b_out, e_out);
        check(n_cbr - b_cbr, e_cbr);
        check(n_open - b_open, e_open);
        check(n_done - b_done, e_done);
        check(n_becn - b_becn, e_becn);
    endtask

    initial begin
        core_clk      = 1'h0;
        rst_n         = 1'h0;
        stall         = 1'h0;
        tx_pkt_valid  = 1'h0;
        tx_pkt_cell   = '0;
        tx_rate_sel   = 3'h0;
        tx_bucket_lim = 8'hFF;
        cbr_valid     = 1'h0;
        cbr_hdr = '{vpi: 12'h000, vci: 16'h0020, pti: 3'h0, clp: 1'h0};
        rid_vci_mid   = 1'h0;
        foreach (gap_cfg[k]) gap_cfg[k] = 16'h0040;
        gap_cfg[3]    = 16'h0100;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'h1;
        repeat (4) @(posedge core_clk);
        t_tx_aal5();
        t_tx_aal34();
        t_cbr();
        rx_case(16'(OAM_VCI_SEG), 3'h0, 0, 0, 0, 0, 0);
        rx_case(16'(OAM_VCI_E2E), 3'h0, 0, 0, 0, 0, 0);
        rx_case(16'(CBR_VCI), 3'h0, 0, 48, 0, 0, 0);
        rx_case(16'h0123, 3'h0, 48, 0, 1, 0, 0);
        check(rx_rid, 26'h004048C);
        @(posedge core_clk);
        rid_vci_mid <= 1'h1;
        rx_case(16'h0123, 3'h1, 48, 0, 0, 1, 0);
        check(rx_rid, 26'h0048D00);
        rx_case(16'(BECN_VCI), 3'h0, 0, 0, 0, 0, 1);
        check(becn_vc, 16'(BECN_VCI));
        check(dut_u.throttle_reg, 3'h1);
        repeat (60) @(negedge core_clk);
        check(dut_u.throttle_reg, 3'h0);
        give_verdict();
    end

    // Whole run needs under two thousand cycles
    initial begin
        #(40 * 30000);
        fails++;
        give_verdict();
    end
endmodule
